// [bit_timer.sv]
// Half-bit tick generator for the serial adapter
module bit_timer #(
  parameter int DIV_W = 21
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] half_div,
  output var  logic             half_tick
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_tick;

  always_comb begin
    next_cnt  = cnt + 1'b1;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = '0;
    end else if (cnt >= half_div - 1'b1) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt       <= '0;
      half_tick <= 1'b0;
    end else if (ce) begin
      cnt       <= next_cnt;
      half_tick <= next_tick;
    end
  end

endmodule

// [data_set_model.sv]
// Data set model: control handshake, bit decoder and receive sender
module data_set_model #(
  parameter int CTS_DLY = 12
) (
  input  wire logic                           clk_sys,
  input  wire serial_adapter_pkg::modem_out_t modem_out,
  output wire serial_adapter_pkg::modem_in_t  modem_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cts_ok = 1'b1, dcd = 1'b1, rbit = 1'b1, rtm = 1'b0, tclk = 1'b0, tprev = 1'b0;
  logic       dsr    = 1'b1;
  logic       ri     = 1'b0;
  logic       ans    = 1'b0;
  logic       ext    = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  int         rts_cnt = 0, gbad = 0, viol = 0, nrx = 0, bitn = 0, tcnt = 0, hi_len = 0, lo_len = 0;
  wire        samp = ext ? tclk : modem_out.tx_timing;
  wire        cts  = modem_out.rts && rts_cnt >= CTS_DLY && cts_ok;
  // Receive line is clamped to Mark while no carrier
  assign modem_in = {dcd ? rbit : 1'b1, cts, dsr, dcd, ri, rtm, tclk};
  // Own transmit timing runs free only while selected
  always #80 tclk = ext & ~tclk;
  always @(posedge clk_sys) begin
    rts_cnt <= modem_out.rts ? rts_cnt + 1 : 0;
    // Auto answer connects only on ringing with terminal ready on
    if (ri && modem_out.dtr) ans <= 1'b1;
    // A few cycles of slack cover the adapter's input synchronisers
    gbad <= (!modem_out.txd && !(modem_out.rts && cts && dsr)) ? gbad + 1 : 0;
    if (gbad == 5) viol <= viol + 1;
    tprev <= modem_out.tx_timing;
    tcnt  <= (modem_out.tx_timing != tprev) ? 1 : tcnt + 1;
    if (modem_out.tx_timing != tprev && tprev) hi_len <= tcnt;
    if (modem_out.tx_timing != tprev && !tprev) lo_len <= tcnt;
  end
  // Samples mid bit, on the falling edge of the timing in use
  always @(negedge samp) begin
    if (bitn == 0 && modem_out.txd === 1'b0) bitn = 1;
    else if (bitn > 0 && bitn < 9) begin
      rx_byte = {modem_out.txd, rx_byte[7:1]};
      bitn++;
    end else if (bitn == 9) begin
      if (modem_out.txd !== 1'b1) viol++;
      nrx++;
      bitn = 0;
    end
  end
  task automatic send(input logic [7:0] b, input int half_ns);
    logic [9:0] f;
    // Line moves on the falling clock, away from the adapter's sampling edge
    @(negedge clk_sys);
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rbit = f[i];
      rtm = 1'b1;
      #(half_ns) rtm = 1'b0;
      #(half_ns);
    end
  endtask
endmodule

// [modem_control_serial_adapter.sv]
// Start-stop serial adapter with modem control lines and AXI4-Lite registers
//
// Behaviour
// - Transmit line idles at Mark
// - Request to send on while data pending
// - Send only with RTS, CTS, DSR on
// - Half duplex: RTS selects send or receive
// - Terminal ready only holds external call
// - Dropping terminal ready releases the line
// - Carrier loss ends activity or faults
// - External transmit timing steps the data
// - Own transmit timing symmetric, falls mid bit
// - Display variant runs 1200 or 2400 baud
// - Telegraph variant runs 45, 57, 75 baud
// - European variant runs 50 or 75 baud
// - Exchange variant runs 110 baud
// - Mark is one, control on is one
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "serial_adapter_defs.svh"

module modem_control_serial_adapter #(
  parameter int ADDR_W    = 8,
  parameter int DATA_BITS = 8,
  parameter int DIV_W     = 21,
  parameter int CLK_HZ    = `CLK_HZ
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  input  wire logic [ADDR_W-1:0]               awaddr,
  input  wire logic                            awvalid,
  output var  logic                            awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output var  logic                            wready,
  output var  logic [1:0]                      bresp,
  output var  logic                            bvalid,
  input  wire logic                            bready,
  input  wire logic [ADDR_W-1:0]               araddr,
  input  wire logic                            arvalid,
  output var  logic                            arready,
  output var  logic [31:0]                     rdata,
  output var  logic [1:0]                      rresp,
  output var  logic                            rvalid,
  input  wire logic                            rready,
  input  wire serial_adapter_pkg::modem_in_t   modem_in,
  output var  serial_adapter_pkg::modem_out_t  modem_out
);

  localparam int CNT_W = $clog2(DATA_BITS + 1);

  function automatic logic [DIV_W-1:0] half_div_of(input serial_adapter_pkg::rate_t r);
    int unsigned baud;
    case (r)
      serial_adapter_pkg::RATE_45:   baud = `BAUD_45;
      serial_adapter_pkg::RATE_50:   baud = `BAUD_50;
      serial_adapter_pkg::RATE_57:   baud = `BAUD_57;
      serial_adapter_pkg::RATE_75:   baud = `BAUD_75;
      serial_adapter_pkg::RATE_1200: baud = `BAUD_1200;
      serial_adapter_pkg::RATE_2400: baud = `BAUD_2400;
      default:                       baud = `BAUD_110;
    endcase
    half_div_of = DIV_W'(CLK_HZ / (2 * baud));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[ADDR_W-1:4] == '0) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: in_s is the settled level, in_d its previous value

  serial_adapter_pkg::modem_in_t in_m, in_s, in_d;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_m <= `PINS_IN_RST;
      in_s <= `PINS_IN_RST;
      in_d <= `PINS_IN_RST;
    end else if (ce) begin
      in_m <= modem_in;
      in_s <= in_m;
      in_d <= in_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state and bus slave

  serial_adapter_pkg::ctrl_t   ctrl, next_ctrl;
  serial_adapter_pkg::status_t status;
  logic [ADDR_W-1:0]    aw_addr, next_aw_addr;
  logic                 aw_got, next_aw_got, w_got, next_w_got;
  logic [31:0]          w_data, next_w_data;
  logic                 w_lane0, next_w_lane0;
  logic                 next_bvalid, next_rvalid;
  logic [1:0]           next_bresp, next_rresp;
  logic [31:0]          next_rdata;
  logic [DATA_BITS-1:0] hold, next_hold, rx_buf, next_rx_buf;
  logic                 hold_full, next_hold_full, rx_valid, next_rx_valid;
  logic [3:0]           sticky, next_sticky, sticky_set;
  logic                 do_write, ar_take, load, rx_deliver, rx_frame_err;
  logic [DATA_BITS-1:0] rx_shift;
  serial_adapter_pkg::tx_state_t tx_state;
  logic [DIV_W-1:0]     half_div;

  assign awready  = !aw_got;
  assign wready   = !w_got;
  assign arready  = !rvalid;
  assign do_write = aw_got && w_got && !bvalid;
  assign ar_take  = arvalid && !rvalid;
  assign half_div = half_div_of(ctrl.rate);

  always_comb begin
    status = '{hold_full: hold_full, tx_busy: tx_state != serial_adapter_pkg::TX_IDLE,
               rx_valid: rx_valid, cts: in_s.cts, dsr: in_s.dsr, dcd: in_s.dcd,
               ri: in_s.ri, sticky: sticky};
  end

  always_comb begin
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_hold = hold;
    next_hold_full = hold_full && !load;
    next_rx_buf = rx_buf;
    next_rx_valid = rx_valid;
    next_sticky = sticky;
    if (awvalid && !aw_got) begin
      next_aw_got  = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && !w_got) begin
      next_w_got   = 1'b1;
      next_w_data  = wdata;
      next_w_lane0 = wstrb[0];
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      if (mapped(aw_addr) && w_lane0) begin
        case (aw_addr[3:0])
          `ADDR_CTRL: next_ctrl = serial_adapter_pkg::ctrl_t'(w_data[7:0]);
          `ADDR_TXDATA: begin
            // A full holding register ignores the write; software polls hold_full
            if (!hold_full) begin
              next_hold      = w_data[DATA_BITS-1:0];
              next_hold_full = 1'b1;
            end
          end
          `ADDR_STATUS: next_sticky = sticky & ~w_data[3:0];
          default: ;
        endcase
      end
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      next_rdata  = '0;
      if (mapped(araddr)) begin
        case (araddr[3:0])
          `ADDR_CTRL:   next_rdata = 32'(ctrl);
          `ADDR_TXDATA: next_rdata = 32'(hold);
          `ADDR_RXDATA: begin
            next_rdata    = 32'(rx_buf);
            next_rx_valid = 1'b0;
          end
          `ADDR_STATUS: next_rdata = 32'(status);
          default: ;
        endcase
      end
    end
    // A new byte wins over the read that clears the previous one
    if (rx_deliver) begin
      next_rx_buf   = rx_shift;
      next_rx_valid = 1'b1;
    end
    next_sticky = next_sticky | sticky_set;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
      w_got <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= '0;
      ctrl <= `CTRL_RST;
      hold <= '0;
      hold_full <= 1'b0;
      rx_buf <= '0;
      rx_valid <= 1'b0;
      sticky <= '0;
    end else if (ce) begin
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      hold <= next_hold;
      hold_full <= next_hold_full;
      rx_buf <= next_rx_buf;
      rx_valid <= next_rx_valid;
      sticky <= next_sticky;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter

  serial_adapter_pkg::tx_state_t next_tx_state;
  logic [DATA_BITS-1:0] tx_shift, next_tx_shift;
  logic [CNT_W-1:0]     tx_cnt, next_tx_cnt;
  logic                 tx_tick, tx_phase, next_tx_phase, tx_gate, tx_step, tx_abort;
  serial_adapter_pkg::modem_out_t next_out;

  bit_timer #(.DIV_W(DIV_W)) tx_timer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .restart   (1'b0),
    .half_div  (half_div),
    .half_tick (tx_tick)
  );

  assign tx_gate = modem_out.rts && in_s.cts && in_s.dsr;
  assign tx_step = ctrl.ext_tx ? (in_s.tx_timing && !in_d.tx_timing)
                               : (tx_tick && !tx_phase);

  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_cnt   = tx_cnt;
    next_tx_phase = tx_tick ? !tx_phase : tx_phase;
    next_out      = modem_out;
    load          = 1'b0;
    tx_abort      = 1'b0;
    next_out.dtr  = ctrl.dtr;
    // Next phase, so the timing rise and the data change leave on one edge
    next_out.tx_timing = next_tx_phase;
    // Off only when nothing waits, nothing is on the line and no hold is asked
    next_out.rts  = ctrl.rts_hold || hold_full || tx_state != serial_adapter_pkg::TX_IDLE;
    case (tx_state)
      serial_adapter_pkg::TX_IDLE: begin
        next_out.txd = 1'b1;
        if (hold_full) next_tx_state = serial_adapter_pkg::TX_WAIT;
      end
      serial_adapter_pkg::TX_WAIT: begin
        if (tx_gate && tx_step) begin
          next_tx_state = serial_adapter_pkg::TX_START;
          next_out.txd  = 1'b0;
          next_tx_shift = hold;
          load          = 1'b1;
        end
      end
      serial_adapter_pkg::TX_START, serial_adapter_pkg::TX_DATA: begin
        // Losing the gate mid character drops it; the line goes back to Mark
        if (!tx_gate) begin
          next_tx_state = serial_adapter_pkg::TX_IDLE;
          next_out.txd  = 1'b1;
          tx_abort      = 1'b1;
        end else if (tx_step) begin
          if (tx_state == serial_adapter_pkg::TX_DATA && tx_cnt == CNT_W'(DATA_BITS)) begin
            next_tx_state = serial_adapter_pkg::TX_STOP;
            next_out.txd  = 1'b1;
          end else begin
            next_tx_state = serial_adapter_pkg::TX_DATA;
            next_out.txd  = tx_shift[0];
            next_tx_shift = tx_shift >> 1;
            next_tx_cnt   = (tx_state == serial_adapter_pkg::TX_START) ? CNT_W'(1)
                                                                       : tx_cnt + 1'b1;
          end
        end
      end
      serial_adapter_pkg::TX_STOP: begin
        if (!tx_gate) begin
          next_tx_state = serial_adapter_pkg::TX_IDLE;
        end else if (tx_step) begin
          if (hold_full) begin
            next_tx_state = serial_adapter_pkg::TX_START;
            next_out.txd  = 1'b0;
            next_tx_shift = hold;
            load          = 1'b1;
          end else begin
            next_tx_state = serial_adapter_pkg::TX_IDLE;
          end
        end
      end
      default: next_tx_state = serial_adapter_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_state  <= serial_adapter_pkg::TX_IDLE;
      tx_shift  <= '0;
      tx_cnt    <= '0;
      tx_phase  <= 1'b0;
      modem_out <= `PINS_OUT_RST;
    end else if (ce) begin
      tx_state  <= next_tx_state;
      tx_shift  <= next_tx_shift;
      tx_cnt    <= next_tx_cnt;
      tx_phase  <= next_tx_phase;
      modem_out <= next_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver

  serial_adapter_pkg::rx_state_t rx_state, next_rx_state;
  logic [DATA_BITS-1:0] next_rx_shift;
  logic [CNT_W-1:0]     rx_cnt, next_rx_cnt;
  logic                 rx_tick, rx_phase, next_rx_phase, rx_sample, rx_abort;

  bit_timer #(.DIV_W(DIV_W)) rx_timer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .restart   (rx_state == serial_adapter_pkg::RX_IDLE),
    .half_div  (half_div),
    .half_tick (rx_tick)
  );

  assign rx_abort  = !in_s.dcd || (ctrl.half_duplex && modem_out.rts);
  assign rx_sample = ctrl.ext_rx ? (!in_s.rx_timing && in_d.rx_timing)
                                 : (rx_tick && (rx_state == serial_adapter_pkg::RX_START
                                                || rx_phase));
  assign sticky_set = {rx_deliver && rx_valid, rx_frame_err,
                       !in_s.dcd && in_d.dcd, tx_abort};

  always_comb begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt   = rx_cnt;
    next_rx_phase = rx_phase;
    rx_deliver    = 1'b0;
    rx_frame_err  = 1'b0;
    if (rx_tick) begin
      next_rx_phase = (rx_state == serial_adapter_pkg::RX_START) ? 1'b0 : !rx_phase;
    end
    case (rx_state)
      serial_adapter_pkg::RX_IDLE: begin
        next_rx_phase = 1'b0;
        if (!rx_abort && !in_s.rxd) next_rx_state = serial_adapter_pkg::RX_START;
      end
      serial_adapter_pkg::RX_START, serial_adapter_pkg::RX_DATA, serial_adapter_pkg::RX_STOP: begin
        if (rx_abort) begin
          next_rx_state = serial_adapter_pkg::RX_IDLE;
        end else if (rx_sample) begin
          if (rx_state == serial_adapter_pkg::RX_START) begin
            // A start that is Mark again at mid bit was a glitch
            next_rx_state = in_s.rxd ? serial_adapter_pkg::RX_IDLE : serial_adapter_pkg::RX_DATA;
            next_rx_cnt   = '0;
          end else if (rx_state == serial_adapter_pkg::RX_DATA) begin
            next_rx_shift = {in_s.rxd, rx_shift[DATA_BITS-1:1]};
            next_rx_cnt   = rx_cnt + 1'b1;
            if (rx_cnt == CNT_W'(DATA_BITS - 1)) next_rx_state = serial_adapter_pkg::RX_STOP;
          end else begin
            next_rx_state = serial_adapter_pkg::RX_IDLE;
            rx_deliver    = in_s.rxd;
            rx_frame_err  = !in_s.rxd;
          end
        end
      end
      default: next_rx_state = serial_adapter_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_state <= serial_adapter_pkg::RX_IDLE;
      rx_shift <= '0;
      rx_cnt   <= '0;
      rx_phase <= 1'b0;
    end else if (ce) begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt   <= next_rx_cnt;
      rx_phase <= next_rx_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [DIV_W-1:0] tick_gap;
  logic             tick_seen;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || $changed(ctrl.rate)) begin
      tick_gap  <= '0;
      tick_seen <= 1'b0;
    end else if (ce) begin
      tick_gap  <= tx_tick ? '0 : tick_gap + 1'b1;
      tick_seen <= tick_seen || tx_tick;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_char_go;
    ce && tx_state == serial_adapter_pkg::TX_WAIT && tx_gate && tx_step;
  endsequence

  sequence s_start_bit;
    !modem_out.txd && tx_state == serial_adapter_pkg::TX_START;
  endsequence

  a_idle_mark: assert property (
    tx_state inside {serial_adapter_pkg::TX_IDLE, serial_adapter_pkg::TX_STOP} |-> modem_out.txd)
    else $error("transmit line not at Mark while idle");
  a_rts_pending: assert property (ce && hold_full |=> modem_out.rts)
    else $error("request to send off with data pending");
  a_send_gated: assert property (!modem_out.txd |-> $past(tx_gate))
    else $error("Space sent without full handshake");
  a_start_space: assert property (s_char_go |=> s_start_bit)
    else $error("character did not open with a Space start bit");
  a_hdx_receive: assert property (
    ctrl.half_duplex && modem_out.rts |=> rx_state == serial_adapter_pkg::RX_IDLE)
    else $error("receiver active while sending in half duplex");
  a_dtr_drop: assert property (
    ce && do_write && aw_addr[3:0] == `ADDR_CTRL && mapped(aw_addr) && w_lane0 && !w_data[0]
    |=> ##1 !modem_out.dtr)
    else $error("terminal ready still on after software cleared it");
  a_carrier_loss: assert property (
    ce && !in_s.dcd && in_d.dcd |=> sticky[`ST_CARRIER_LOST]
      && rx_state == serial_adapter_pkg::RX_IDLE)
    else $error("carrier loss not flagged or receiver not stopped");
  a_ext_step: assert property (
    ctrl.ext_tx && $changed(modem_out.txd) && $past(tx_gate) && $past(ctrl.ext_tx)
    |-> $past(in_s.tx_timing && !in_d.tx_timing))
    else $error("data changed without a transmit timing edge");
  a_own_timing: assert property (
    !ctrl.ext_tx && !$past(ctrl.ext_tx) && $changed(modem_out.txd) && $past(tx_gate)
    |-> $rose(modem_out.tx_timing))
    else $error("data changed away from rising edge of own timing");
  // The tick just after a rate write ends a period begun under the old rate; tick_gap restarts at the write
  a_half_bit: assert property (
    tx_tick && tick_seen && $stable(ctrl.rate) |-> tick_gap == half_div - 1'b1)
    else $error("half bit period differs from selected rate");

endmodule

// [modem_control_serial_adapter_tb.sv]
// Self-checking bench for the modem control serial adapter
module modem_control_serial_adapter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLK_HZ = 24000;
  logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, q;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  r;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire serial_adapter_pkg::modem_in_t  mi;
  wire serial_adapter_pkg::modem_out_t mo;
  int          err_total = 0, checks = 0, cyc = 0, n;
  int          bd[7] = '{45, 50, 57, 75, 110, 1200, 2400};
  modem_control_serial_adapter #(.CLK_HZ(CLK_HZ)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .modem_in(mi), .modem_out(mo));
  data_set_model ds (.clk_sys(clk_sys), .modem_out(mo), .modem_in(mi));
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Ready levels are sampled at the falling edge; they only move at rising edges
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic sa, sw, sr, b;
    b = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    bready <= wr;
    rready <= !wr;
    while (!b) begin
      @(negedge clk_sys);
      {sa, sw, sr} = {awready, wready, arready};
      b = wr ? bvalid : rvalid;
      r = wr ? bresp : rresp;
      q = rdata;
      @(posedge clk_sys);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      if (sr) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic wait_tx(input int target);
    for (int i = 0; i < 15000 && ds.nrx < target; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("modem_out", 32'h8, 32'(mo));
    xfer(0, 8'h00, 0);
    chk("ctrl", 32'h0, q);
    xfer(1, 8'h10, 32'h1);
    chk("wr_resp", 32'h2, 32'(r));
    xfer(0, 8'h10, 0);
    chk("rd_resp", 32'h2, 32'(r));
    chk("rd_data", 32'h0, q);
    $display("reset test done");
  endtask
  task automatic t_rates;
    for (int k = 0; k < 7; k++) begin
      n = ds.nrx;
      xfer(1, 8'h00, 32'(k * 32 + 1));
      xfer(1, 8'h04, 32'(49 + k));
      wait_tx(n + 1);
      chk("tx_byte", 32'(49 + k), 32'(ds.rx_byte));
      chk("half_hi", CLK_HZ / (2 * bd[k]), ds.hi_len);
      chk("half_lo", CLK_HZ / (2 * bd[k]), ds.lo_len);
    end
    n = ds.nrx;
    xfer(1, 8'h04, 32'h96);
    q = 32'h400;
    for (int i = 0; i < 500 && q[10]; i++) xfer(0, 8'h0c, 0);
    xfer(1, 8'h04, 32'h69);
    wait_tx(n + 2);
    chk("b2b_byte", 32'h69, 32'(ds.rx_byte));
    repeat (30) @(posedge clk_sys);
    chk("rts_idle", 32'h0, 32'(mo.rts));
    chk("gate_viol", 32'h0, ds.viol);
    $display("rates test done");
  endtask
  task automatic t_gate;
    n = ds.nrx;
    ds.cts_ok <= 1'b0;
    xfer(1, 8'h04, 32'h3c);
    repeat (100) @(posedge clk_sys);
    chk("rts_wait", 32'h1, 32'(mo.rts));
    chk("txd_wait", 32'h1, 32'(mo.txd));
    ds.cts_ok <= 1'b1;
    wait_tx(n + 1);
    chk("gate_byte", 32'h3c, 32'(ds.rx_byte));
    xfer(1, 8'h04, 32'h00);
    for (int i = 0; i < 300 && mo.txd; i++) @(posedge clk_sys);
    repeat (25) @(posedge clk_sys);
    ds.dsr <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("txd_abort", 32'h1, 32'(mo.txd));
    xfer(0, 8'h0c, 0);
    chk("abort_flag", 32'h1, 32'(q[0]));
    ds.dsr <= 1'b1;
    repeat (100) @(posedge clk_sys);
    xfer(1, 8'h0c, 32'hf);
    xfer(0, 8'h0c, 0);
    chk("sticky_clr", 32'h0, 32'(q[3:0]));
    $display("gate test done");
  endtask
  task automatic t_ext;
    ds.ext <= 1'b1;
    xfer(1, 8'h00, 32'hc9);
    n = ds.nrx;
    xfer(1, 8'h04, 32'ha7);
    wait_tx(n + 1);
    chk("ext_byte", 32'ha7, 32'(ds.rx_byte));
    xfer(1, 8'h00, 32'hc1);
    ds.ext <= 1'b0;
    $display("ext timing test done");
  endtask
  task automatic t_rx;
    ds.send(8'ha5, 40);
    xfer(0, 8'h0c, 0);
    chk("rx_valid", 32'h1, 32'(q[8]));
    xfer(0, 8'h08, 0);
    chk("rx_byte", 32'ha5, 32'(q[7:0]));
    xfer(1, 8'h00, 32'hd1);
    ds.send(8'h4b, 80);
    xfer(0, 8'h08, 0);
    chk("ext_rx_byte", 32'h4b, 32'(q[7:0]));
    fork
      ds.send(8'h0f, 80);
      begin
        repeat (60) @(posedge clk_sys);
        ds.dcd <= 1'b0;
      end
    join
    xfer(0, 8'h0c, 0);
    chk("dcd_lost", 32'h1, 32'({q[5], q[1]}));
    ds.dcd <= 1'b1;
    xfer(1, 8'h00, 32'hc7);
    ds.send(8'h33, 40);
    xfer(0, 8'h0c, 0);
    chk("hdx_rx_idle", 32'h0, 32'(q[8]));
    chk("rts_hold", 32'h1, 32'(mo.rts));
    xfer(1, 8'h00, 32'hc1);
    $display("receive test done");
  endtask
  task automatic t_ring;
    xfer(1, 8'h00, 32'hc0);
    repeat (4) @(posedge clk_sys);
    chk("dtr_off", 32'h0, 32'(mo.dtr));
    ds.ri <= 1'b1;
    repeat (4) @(posedge clk_sys);
    xfer(0, 8'h0c, 0);
    chk("ring_seen", 32'h1, 32'(q[4]));
    chk("no_answer", 32'h0, 32'(ds.ans));
    ds.ri <= 1'b0;
    xfer(1, 8'h00, 32'hc1);
    repeat (4) @(posedge clk_sys);
    chk("dtr_on", 32'h1, 32'(mo.dtr));
    $display("ring test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_rates();
    t_gate();
    t_ext();
    t_rx();
    t_ring();
    results();
  end
endmodule

// [serial_adapter_defs.svh]
// Offsets, reset values, field positions and line rates of the serial adapter
`ifndef SERIAL_ADAPTER_DEFS_SVH
`define SERIAL_ADAPTER_DEFS_SVH

`define ADDR_CTRL       4'h0
`define ADDR_TXDATA     4'h4
`define ADDR_RXDATA     4'h8
`define ADDR_STATUS     4'hc

`define CTRL_RST        8'h00
`define PINS_IN_RST     7'h40
`define PINS_OUT_RST    4'h8

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define ST_TX_ABORT     0
`define ST_CARRIER_LOST 1
`define ST_FRAME_ERR    2
`define ST_RX_OVERRUN   3

`define CLK_HZ          125000000
`define BAUD_45         45
`define BAUD_50         50
`define BAUD_57         57
`define BAUD_75         75
`define BAUD_110        110
`define BAUD_1200       1200
`define BAUD_2400       2400

`endif

// [serial_adapter_pkg.sv]
// Types shared by the serial adapter files
package serial_adapter_pkg;

  typedef enum logic [2:0] {
    RATE_45, RATE_50, RATE_57, RATE_75, RATE_110, RATE_1200, RATE_2400
  } rate_t;

  typedef struct packed {
    rate_t rate;
    logic  ext_rx;
    logic  ext_tx;
    logic  half_duplex;
    logic  rts_hold;
    logic  dtr;
  } ctrl_t;

  typedef struct packed {
    logic rxd;
    logic cts;
    logic dsr;
    logic dcd;
    logic ri;
    logic rx_timing;
    logic tx_timing;
  } modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts;
    logic dtr;
    logic tx_timing;
  } modem_out_t;

  typedef struct packed {
    logic       hold_full;
    logic       tx_busy;
    logic       rx_valid;
    logic       cts;
    logic       dsr;
    logic       dcd;
    logic       ri;
    logic [3:0] sticky;
  } status_t;

  typedef enum {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage
